//--- plcr_defs.vh
`ifndef PLCR_DEFS_VH
`define PLCR_DEFS_VH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define PLCR_LINK_CAP_ADDR 8'hAC
`define PLCR_LINK_CTL_ADDR 8'hB0
`define PLCR_LINK_STS_ADDR 8'hB2
// ---------------------------------------------------------------
// link capabilities fields and reset values
// ---------------------------------------------------------------
`define PLCR_CAP_PORT_NUM 8'h02
`define PLCR_CAP_BW_NOTIFY 21
`define PLCR_CAP_CLK_REMOVE 18
`define PLCR_CAP_L1LAT_HI 17
`define PLCR_CAP_L1LAT_LO 15
`define PLCR_CAP_RSVD14_12 3'h4
`define PLCR_CAP_ASPM_HI 11
`define PLCR_CAP_ASPM_LO 10
`define PLCR_CAP_WIDTH_HI 9
`define PLCR_CAP_WIDTH_LO 4
`define PLCR_CAP_SPEED_HI 3
`define PLCR_CAP_SPEED_LO 0
`define PLCR_L1LAT_RST 3'h2
`define PLCR_ASPM_RST 2'h3
`define PLCR_WIDTH_RST 6'h10
`define PLCR_SPEED_RST 4'h2
`define PLCR_SPEED_GEN1 4'h1
`define PLCR_SPEED_GEN2 4'h2
// ---------------------------------------------------------------
// link control / status bits
// ---------------------------------------------------------------
`define PLCR_CTL_RST 16'h0000
`define PLCR_CTL_AUTO_BW_IE 11
`define PLCR_CTL_BW_MGMT_IE 10
`define PLCR_CTL_AUTO_WIDTH_DIS 9
`define PLCR_CTL_CLK_PM_EN 8
`define PLCR_STS_AUTO_BW 15
`define PLCR_STS_BW_MGMT 14
`endif

//--- plcr_wo_field.v
`timescale 1ns/1ps
`default_nettype none
// write-once field: a write lands only while no earlier lock_en has been seen since reset
module plcr_wo_field #(
    parameter W = 4,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input wire clock,
    input wire resetn,
    input wire wr_en,
    input wire [W-1:0] wr_data,
    input wire lock_en,
    output reg [W-1:0] value_r
);
    reg locked_r;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            value_r <= RST;
            locked_r <= 1'b0;
        end else begin
            if (wr_en && !locked_r) begin
                value_r <= wr_data;
            end
            if (lock_en) begin
                locked_r <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- plcr_link_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "plcr_defs.vh"
module plcr_link_regs #(
    parameter BW_NOTIFY_CAP = 1'b1,
    parameter CLK_REMOVE_CAP = 1'b0
) (
    input wire clock,
    input wire resetn,
    // ---------------------------------------------------------------
    // configuration access, dword addressed, byte enables
    // ---------------------------------------------------------------
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [3:0] cfg_be,
    input wire [31:0] cfg_wdata,
    output reg [31:0] cfg_rdata_r,
    // ---------------------------------------------------------------
    // link layer events
    // ---------------------------------------------------------------
    input wire hw_auto_bw_change,
    input wire hw_corrective_change,
    input wire retrain_done,
    input wire clkreq_req,
    output reg autonomous_width_disable_r,
    output reg clock_pm_enable_r,
    output reg clkreq_n_r,
    output reg irq_r
);
    reg autonomous_bw_irq_enable_r;
    reg bw_mgmt_irq_enable_r;
    reg autonomous_bw_status_r;
    reg bw_mgmt_status_r;
    wire [2:0] l1_exit_latency;
    wire [1:0] aspm_support;
    wire [5:0] max_lane_count;
    wire [3:0] max_speed_code;
    // byte addresses held at full width so the dword part can be selected without a shift
    localparam [7:0] CAP_ADDR = `PLCR_LINK_CAP_ADDR;
    localparam [7:0] CTL_ADDR = `PLCR_LINK_CTL_ADDR;
    // one-bit views of the capability parameters for the event gates and the read word
    localparam [0:0] BW_NOTIFY_BIT = BW_NOTIFY_CAP;
    localparam [0:0] CLK_REMOVE_BIT = CLK_REMOVE_CAP;
    wire cap_sel = (cfg_addr[7:2] == CAP_ADDR[7:2]);
    wire ctl_sel = (cfg_addr[7:2] == CTL_ADDR[7:2]);
    wire cap_wr = cfg_wr && cap_sel;
    wire ctl_wr = cfg_wr && ctl_sel && cfg_be[1];
    wire sts_wr = cfg_wr && ctl_sel && cfg_be[3];
    wire cap_any_wr = cap_wr && (cfg_be[2:0] != 3'h0);
    // ---------------------------------------------------------------
    // write-once capability fields
    // ---------------------------------------------------------------
    // the latency field spans bytes 1 and 2; a partial write would latch a mixed value,
    // so it lands only when both lanes are enabled
    plcr_wo_field #(.W(3), .RST(`PLCR_L1LAT_RST)) u_l1lat (
        .clock(clock),
        .resetn(resetn),
        .wr_en(cap_wr && cfg_be[1] && cfg_be[2]),
        .wr_data(cfg_wdata[`PLCR_CAP_L1LAT_HI:`PLCR_CAP_L1LAT_LO]),
        .lock_en(cap_any_wr),
        .value_r(l1_exit_latency)
    );
    plcr_wo_field #(.W(2), .RST(`PLCR_ASPM_RST)) u_aspm (
        .clock(clock),
        .resetn(resetn),
        .wr_en(cap_wr && cfg_be[1]),
        .wr_data(cfg_wdata[`PLCR_CAP_ASPM_HI:`PLCR_CAP_ASPM_LO]),
        .lock_en(cap_any_wr),
        .value_r(aspm_support)
    );
    plcr_wo_field #(.W(6), .RST(`PLCR_WIDTH_RST)) u_width (
        .clock(clock),
        .resetn(resetn),
        .wr_en(cap_wr && cfg_be[0] && cfg_be[1]),
        .wr_data(cfg_wdata[`PLCR_CAP_WIDTH_HI:`PLCR_CAP_WIDTH_LO]),
        .lock_en(cap_any_wr),
        .value_r(max_lane_count)
    );
    plcr_wo_field #(.W(4), .RST(`PLCR_SPEED_RST)) u_speed (
        .clock(clock),
        .resetn(resetn),
        .wr_en(cap_wr && cfg_be[0]),
        .wr_data(cfg_wdata[`PLCR_CAP_SPEED_HI:`PLCR_CAP_SPEED_LO]),
        .lock_en(cap_any_wr),
        .value_r(max_speed_code)
    );
    // ---------------------------------------------------------------
    // link control and status: event decode
    // ---------------------------------------------------------------
    // a corrective change is never reported as autonomous, even when both strobes
    // arrive together; without the notification capability neither flag can set
    wire auto_bw_event = hw_auto_bw_change && !hw_corrective_change && BW_NOTIFY_BIT;
    wire bw_mgmt_event = (retrain_done || hw_corrective_change) && BW_NOTIFY_BIT;
    // status flags clear when software writes a one to them in the upper half
    wire auto_bw_clear = sts_wr && cfg_wdata[16 + `PLCR_STS_AUTO_BW];
    wire bw_mgmt_clear = sts_wr && cfg_wdata[16 + `PLCR_STS_BW_MGMT];
    // ---------------------------------------------------------------
    // next-state logic for control and status
    // ---------------------------------------------------------------
    reg autonomous_bw_irq_enable_nxt;
    reg bw_mgmt_irq_enable_nxt;
    reg autonomous_bw_status_nxt;
    reg bw_mgmt_status_nxt;
    reg clkreq_n_nxt;
    reg irq_nxt;
    always @* begin
        autonomous_bw_irq_enable_nxt = autonomous_bw_irq_enable_r;
        bw_mgmt_irq_enable_nxt = bw_mgmt_irq_enable_r;
        if (ctl_wr) begin
            // without the notification capability the enable never leaves zero
            autonomous_bw_irq_enable_nxt = BW_NOTIFY_BIT ? cfg_wdata[`PLCR_CTL_AUTO_BW_IE] : 1'b0;
            bw_mgmt_irq_enable_nxt = cfg_wdata[`PLCR_CTL_BW_MGMT_IE];
        end
    end
    // a hardware event in the same cycle as a software clear wins, so no event is lost
    always @* begin
        autonomous_bw_status_nxt = autonomous_bw_status_r;
        bw_mgmt_status_nxt = bw_mgmt_status_r;
        if (auto_bw_event) begin
            autonomous_bw_status_nxt = 1'b1;
        end else if (auto_bw_clear) begin
            autonomous_bw_status_nxt = 1'b0;
        end
        if (bw_mgmt_event) begin
            bw_mgmt_status_nxt = 1'b1;
        end else if (bw_mgmt_clear) begin
            bw_mgmt_status_nxt = 1'b0;
        end
    end
    always @* begin
        // clock request held low unless clock power management is enabled
        clkreq_n_nxt = clock_pm_enable_r ? !clkreq_req : 1'b0;
        // level request: it drops one cycle after the flag is cleared or its enable goes
        irq_nxt = (autonomous_bw_status_r && autonomous_bw_irq_enable_r) ||
            (bw_mgmt_status_r && bw_mgmt_irq_enable_r);
    end
    // ---------------------------------------------------------------
    // control and status registers
    // ---------------------------------------------------------------
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            autonomous_bw_irq_enable_r <= 1'b0;
            bw_mgmt_irq_enable_r <= 1'b0;
            autonomous_width_disable_r <= 1'b0;
            clock_pm_enable_r <= 1'b0;
            autonomous_bw_status_r <= 1'b0;
            bw_mgmt_status_r <= 1'b0;
            clkreq_n_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            autonomous_bw_irq_enable_r <= autonomous_bw_irq_enable_nxt;
            bw_mgmt_irq_enable_r <= bw_mgmt_irq_enable_nxt;
            // width disable is read-only and stays clear: no write path reaches it
            autonomous_width_disable_r <= 1'b0;
            // the enable is read-only here and tied off, even where CLK_REMOVE_CAP offers clock removal
            clock_pm_enable_r <= 1'b0;
            autonomous_bw_status_r <= autonomous_bw_status_nxt;
            bw_mgmt_status_r <= bw_mgmt_status_nxt;
            clkreq_n_r <= clkreq_n_nxt;
            irq_r <= irq_nxt;
        end
    end
    // ---------------------------------------------------------------
    // read data, one cycle after the read strobe
    // ---------------------------------------------------------------
    wire [31:0] cap_word;
    wire [31:0] ctl_word;
    reg [31:0] cfg_rdata_nxt;
    assign cap_word = {`PLCR_CAP_PORT_NUM, 2'h0, BW_NOTIFY_BIT, 2'h0,
        CLK_REMOVE_BIT, l1_exit_latency, `PLCR_CAP_RSVD14_12,
        aspm_support, max_lane_count, max_speed_code};
    assign ctl_word = {autonomous_bw_status_r, bw_mgmt_status_r, 14'h0000,
        4'h0, autonomous_bw_irq_enable_r, bw_mgmt_irq_enable_r,
        autonomous_width_disable_r, clock_pm_enable_r, 8'h00};
    // the data register holds between reads, so a slow reader still finds it standing
    always @* begin
        cfg_rdata_nxt = cfg_rdata_r;
        if (cfg_rd) begin
            if (cap_sel) begin
                cfg_rdata_nxt = cap_word;
            end else if (ctl_sel) begin
                cfg_rdata_nxt = ctl_word;
            end else begin
                cfg_rdata_nxt = 32'h00000000;
            end
        end
    end
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_rdata_r <= 32'h00000000;
        end else begin
            cfg_rdata_r <= cfg_rdata_nxt;
        end
    end
endmodule
`default_nettype wire

//--- plcr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module plcr_chk (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata_r,
    input wire logic hw_auto_bw_change,
    input wire logic hw_corrective_change,
    input wire logic retrain_done,
    input wire logic clkreq_req,
    input wire logic autonomous_width_disable_r,
    input wire logic clock_pm_enable_r,
    input wire logic clkreq_n_r,
    input wire logic irq_r
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire logic rd_cap = cfg_rd && cfg_addr[7:2] == 6'h2B;
    wire logic rd_ctl = cfg_rd && cfg_addr[7:2] == 6'h2C;
    a_cap_fixed: assert property (rd_cap |=> cfg_rdata_r[31:18] == 14'h0088) else $error("cap fixed bits");
    a_ctl_rsvd: assert property (rd_ctl |=> cfg_rdata_r[15:12] == 4'h0) else $error("ctl reserved");
    a_width_ro: assert property (rd_ctl |=> !cfg_rdata_r[9] && !autonomous_width_disable_r) else $error("width dis");
    a_cpm_tied: assert property (rd_ctl |=> !cfg_rdata_r[8] && !clock_pm_enable_r) else $error("clock pm en");
    // the request pin is registered from the enable, one cycle behind it
    a_clkreq_low: assert property (!clock_pm_enable_r |=> !clkreq_n_r) else $error("clock request");
    // irq lags the flags by one cycle, exactly like the read data
    a_irq_follow: assert property (rd_ctl |=> irq_r == (cfg_rdata_r[31] && cfg_rdata_r[11]
        || cfg_rdata_r[30] && cfg_rdata_r[10])) else $error("irq vs flags");
    a_rd_hold: assert property (!cfg_rd |=> $stable(cfg_rdata_r)) else $error("read data moved");
    a_unmapped_read: assert property (cfg_rd && !rd_cap && !rd_ctl |=> cfg_rdata_r == 32'h0) else $error("unmapped");
    c_cap_rd: cover property (rd_cap);
    c_irq: cover property (retrain_done ##3 irq_r);
    c_ctl_wr: cover property (cfg_wr && cfg_addr == 8'hB0);
endmodule
bind plcr_link_regs plcr_chk plcr_chk_inst (
    .clock(clock),
    .resetn(resetn),
    .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr),
    .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata),
    .cfg_rdata_r(cfg_rdata_r),
    .hw_auto_bw_change(hw_auto_bw_change),
    .hw_corrective_change(hw_corrective_change),
    .retrain_done(retrain_done),
    .clkreq_req(clkreq_req),
    .autonomous_width_disable_r(autonomous_width_disable_r),
    .clock_pm_enable_r(clock_pm_enable_r),
    .clkreq_n_r(clkreq_n_r),
    .irq_r(irq_r)
);
`default_nettype wire

//--- plcr_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// link side: turns a kick code into one event pulse
module plcr_link_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [1:0] kick,
    output logic hw_auto_bw_change,
    output logic hw_corrective_change,
    output logic retrain_done,
    output logic clkreq_req
);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            {hw_auto_bw_change, hw_corrective_change, retrain_done, clkreq_req} <= 4'h0;
        end else begin
            hw_auto_bw_change <= kick == 2'h1;
            hw_corrective_change <= kick == 2'h2;
            retrain_done <= kick == 2'h3;
            clkreq_req <= 1'($urandom_range(1));
        end
    end
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 0, resetn = 0, cfg_wr = 0, cfg_rd = 0, rd_d = 0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, v, cap;
    logic [1:0] kick = 2'h0;
    wire logic [31:0] cfg_rdata_r;
    wire logic hw_auto_bw_change, hw_corrective_change, retrain_done, clkreq_req;
    wire logic autonomous_width_disable_r, clock_pm_enable_r, clkreq_n_r, irq_r;
    logic [31:0] expq[$];
    int error_cnt = 0, n_checks = 0;
    always #20 clock = ~clock;
    plcr_link_regs plcr_link_regs_inst (
        .clock(clock),
        .resetn(resetn),
        .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr),
        .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata),
        .cfg_rdata_r(cfg_rdata_r),
        .hw_auto_bw_change(hw_auto_bw_change),
        .hw_corrective_change(hw_corrective_change),
        .retrain_done(retrain_done),
        .clkreq_req(clkreq_req),
        .autonomous_width_disable_r(autonomous_width_disable_r),
        .clock_pm_enable_r(clock_pm_enable_r),
        .clkreq_n_r(clkreq_n_r),
        .irq_r(irq_r)
    );
    plcr_link_model plcr_link_model_inst (
        .clock(clock),
        .resetn(resetn),
        .kick(kick),
        .hw_auto_bw_change(hw_auto_bw_change),
        .hw_corrective_change(hw_corrective_change),
        .retrain_done(retrain_done),
        .clkreq_req(clkreq_req)
    );
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_irq(input logic e);
        n_checks++;
        if (irq_r !== e) begin
            error_cnt++;
            $display("mismatch irq expected %b seen %b", e, irq_r);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clock);
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} <= {w, !w, a, be, d};
        @(posedge clock);
        {cfg_wr, cfg_rd} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        acc(1'b0, a, 4'hF, 32'h0);
    endtask
    task automatic ev(input logic [1:0] k);
        @(posedge clock);
        kick <= k;
        @(posedge clock);
        kick <= 2'h0;
        repeat (4) @(posedge clock);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // read data lands one edge after the read is taken
    always @(posedge clock) begin
        rd_d <= cfg_rd;
        if (rd_d) chk("rdata", expq.pop_front(), cfg_rdata_r);
    end
    initial begin
        #400000;
        error_cnt++;
        end_sim;
    end
    initial begin
        void'($urandom(32'h95242C47));
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        // clock removal reads as not offered, so software keeps the reference clock
        rd(8'hAC, 32'h02214D02);
        rd(8'hB0, 32'h0);
        acc(1'b1, 8'hB0, 4'h3, 32'h0000FF00);
        rd(8'hB2, 32'h00000C00);
        ev(2'h3);
        chk_irq(1'b1);
        rd(8'hB0, 32'h40000C00);
        acc(1'b1, 8'hB0, 4'h8, 32'h40000000);
        ev(2'h1);
        rd(8'hB0, 32'h80000C00);
        ev(2'h2);
        rd(8'hB0, 32'hC0000C00);
        // clearing both flags also drops both enables, so the next event stays quiet
        acc(1'b1, 8'hB0, 4'hF, 32'hC0000000);
        ev(2'h3);
        chk_irq(1'b0);
        rd(8'hB0, 32'h40000000);
        // a retrain event and a software clear land in one cycle: the event must win
        fork
            ev(2'h3);
            begin
                @(posedge clock);
                acc(1'b1, 8'hB0, 4'h8, 32'h40000000);
            end
        join
        rd(8'hB0, 32'h40000000);
        v = $urandom;
        v[3:0] = 4'h1;
        acc(1'b1, 8'hAC, 4'h7, v);
        cap = {11'h011, 3'h0, v[17:15], 3'h4, v[11:0]};
        rd(8'hAC, cap);
        acc(1'b1, 8'hAC, 4'hF, ~v);
        rd(8'hAC, cap);
        rd(8'hB4, 32'h0);
        repeat (2) @(posedge clock);
        end_sim;
    end
endmodule
`default_nettype wire
